// ===== dv/ffpi_port_chk.sv
// Pin-level protocol checker for the parallel flash programming port.
`timescale 1ns/1ps
`default_nettype none

module ffpi_port_chk #(
	parameter int unsigned DATA_W = 16
) (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic srst_i,
	// Handshake pins.
	input wire logic command_strobe_n_i,
	input wire logic output_enable_n_i,
	input wire logic ready_o,
	input wire logic data_valid_n_o,
	input wire logic [DATA_W-1:0] data_o,
	input wire logic data_oe_o,
	input wire logic ext_clock_select_o,
	// Back-end pins.
	input wire logic mem_rd_req_o,
	input wire logic page_prog_req_o,
	input wire logic page_prog_done_i,
	input wire logic page_erase_o,
	input wire logic page_lock_o
);
	// One clock domain, so one default clock and reset cover every check.
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	property p_reset_idle;
		$fell(srst_i) |-> !ready_o && data_valid_n_o && !data_oe_o && !page_prog_req_o;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("port not idle after reset");
	property p_drop_on_strobe;
		$fell(ready_o) |-> !command_strobe_n_i && !$past(command_strobe_n_i, 2);
	endproperty
	a_drop_on_strobe: assert property (p_drop_on_strobe) else $error("ready fell without strobe");
	property p_rise_on_strobe;
		$rose(ready_o) |-> command_strobe_n_i && $past(command_strobe_n_i, 2);
	endproperty
	a_rise_on_strobe: assert property (p_rise_on_strobe) else $error("ready rose under strobe");
	property p_drive_after_oe;
		$rose(data_oe_o) |-> !$past(output_enable_n_i, 2) && !ready_o ##1 !data_valid_n_o;
	endproperty
	a_drive_after_oe: assert property (p_drive_after_oe) else $error("bad drive start");
	property p_oe_answer;
		$fell(output_enable_n_i) && !ready_o |-> ##[1:12] !data_valid_n_o;
	endproperty
	a_oe_answer: assert property (p_oe_answer) else $error("no valid after enable");
	property p_release_on_oe;
		$rose(data_valid_n_o) |-> !data_oe_o && $past(data_oe_o) && $past(output_enable_n_i, 2);
	endproperty
	a_release_on_oe: assert property (p_release_on_oe) else $error("bad bus release");
	property p_valid_window;
		!data_valid_n_o |-> data_oe_o && !ready_o;
	endproperty
	a_valid_window: assert property (p_valid_window) else $error("valid outside window");
	property p_data_stands;
		data_oe_o && $past(data_oe_o) |-> $stable(data_o);
	endproperty
	a_data_stands: assert property (p_data_stands) else $error("read data moved");
	property p_quiet_when_ready;
		ready_o |-> !data_oe_o && !page_prog_req_o && !mem_rd_req_o;
	endproperty
	a_quiet_when_ready: assert property (p_quiet_when_ready) else $error("busy while ready");
	property p_commit_holds;
		page_prog_req_o && !page_prog_done_i |=> page_prog_req_o;
	endproperty
	a_commit_holds: assert property (p_commit_holds) else $error("commit dropped early");

	// Main scenarios that the bench is expected to reach.
	c_read: cover property ($fell(data_valid_n_o));
	c_erase_lock: cover property (page_prog_req_o && page_erase_o && page_lock_o);
	c_ext_clock: cover property ($rose(ext_clock_select_o));
endmodule : ffpi_port_chk

bind ffpi_port ffpi_port_chk #(.DATA_W(DATA_W)) u_ffpi_port_chk (
	.mclk_i(mclk_i),
	.srst_i(srst_i),
	.command_strobe_n_i(command_strobe_n_i),
	.output_enable_n_i(output_enable_n_i),
	.ready_o(ready_o),
	.data_valid_n_o(data_valid_n_o),
	.data_o(data_o),
	.data_oe_o(data_oe_o),
	.ext_clock_select_o(ext_clock_select_o),
	.mem_rd_req_o(mem_rd_req_o),
	.page_prog_req_o(page_prog_req_o),
	.page_prog_done_i(page_prog_done_i),
	.page_erase_o(page_erase_o),
	.page_lock_o(page_lock_o)
);

`default_nettype wire

// ===== dv/ffpi_prog_model.sv
// Behavioural parallel programmer that drives the handshake pins of the port.
`timescale 1ns/1ps
`default_nettype none

module ffpi_prog_model (
	// Clock.
	input wire logic mclk_i,
	// Device answers and the resolved data lines.
	input wire logic ready_i,
	input wire logic valid_n_i,
	input wire logic [15:0] dat_i,
	// Programmer drives.
	output logic strobe_n_o,
	output logic oe_n_o,
	output logic [3:0] mode_o,
	output logic [15:0] dat_o,
	output logic en_o,
	output logic hang_o
);
	// Released lines sit at their pull-up level; mode 4'hf is an idle code.
	initial begin
		strobe_n_o = 1'b1;
		oe_n_o = 1'b1;
		mode_o = 4'hf;
		dat_o = 16'hffff;
		en_o = 1'b0;
		hang_o = 1'b0;
	end

	// Waits for ready (s=0) or valid (s=1) to reach a level; a stuck device raises hang.
	task automatic wt(input bit s, input logic v);
		int n;
		n = 0;
		do begin
			@(posedge mclk_i);
			n++;
		end while (((s ? valid_n_i : ready_i) !== v) && n < 4000);
		if (n >= 4000) hang_o = 1'b1;
		#1;
	endtask : wt

	// Write handshake; mode and data settle six cycles before the strobe so the pin filters agree.
	task automatic wr(input logic [3:0] m, input logic [15:0] d);
		wt(1'b0, 1'b1);
		mode_o = m;
		dat_o = d;
		en_o = 1'b1;
		repeat (6) @(posedge mclk_i);
		#1 strobe_n_o = 1'b0;
		wt(1'b0, 1'b0);
		mode_o = 4'hf;
		en_o = 1'b0;
		@(posedge mclk_i);
		#1 strobe_n_o = 1'b1;
		wt(1'b0, 1'b1);
	endtask : wr

	// Read handshake; the bus is floated before the enable is lowered to avoid contention.
	task automatic rd(output logic [15:0] v);
		wt(1'b0, 1'b1);
		mode_o = 4'h5;
		en_o = 1'b1;
		repeat (6) @(posedge mclk_i);
		#1 strobe_n_o = 1'b0;
		wt(1'b0, 1'b0);
		mode_o = 4'hf;
		en_o = 1'b0;
		@(posedge mclk_i);
		#1 oe_n_o = 1'b0;
		wt(1'b1, 1'b0);
		v = dat_i;
		oe_n_o = 1'b1;
		wt(1'b1, 1'b1);
		strobe_n_o = 1'b1;
		wt(1'b0, 1'b1);
	endtask : rd
endmodule : ffpi_prog_model

`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for the parallel flash programming port.
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import ffpi_pkg::*;
;
	logic mclk_i = 1'b0;
	logic srst_i = 1'b1;
	logic ext_clk = 1'b0;
	logic rd_done = 1'b0;
	logic pdone = 1'b0;
	logic [15:0] rd_data = 16'h0000;
	logic [1:0] buf_idx = 2'h0;
	wire logic strobe_n, oe_n, ready, valid_n, data_oe, hang, drv_en, rd_req, prog_req;
	wire logic erase, lock, ext_sel;
	wire logic [3:0] mode;
	wire logic [15:0] drv_data, data_out, bus, buf_word;
	wire logic [31:0] rd_addr, prog_addr;
	int fail_count = 0;
	int n_tests = 0;
	logic [31:0] c_addr[$];
	logic [1:0] c_fl[$];
	logic [63:0] c_w[$];

	always #20 mclk_i = ~mclk_i;
	// A quarter-rate external clock gives the shortened detection window several edges.
	always #80 ext_clk = ~ext_clk;
	// Pull-ups hold the data lines high whenever nobody drives them.
	assign bus = data_oe ? data_out : (drv_en ? drv_data : 16'hffff);

	ffpi_port #(.PAGE_WORDS(4), .DETECT_CYC(16)) u_ffpi_port (
		.mclk_i(mclk_i), .srst_i(srst_i), .ext_clock_in_i(ext_clk), .ext_clock_select_o(ext_sel),
		.command_strobe_n_i(strobe_n), .output_enable_n_i(oe_n), .ready_o(ready),
		.data_valid_n_o(valid_n), .mode_i(mode), .data_i(bus), .data_o(data_out),
		.data_oe_o(data_oe), .mem_rd_req_o(rd_req), .mem_rd_addr_o(rd_addr),
		.mem_rd_data_i(rd_data), .mem_rd_done_i(rd_done), .page_prog_req_o(prog_req),
		.page_prog_addr_o(prog_addr), .page_erase_o(erase), .page_lock_o(lock),
		.page_prog_done_i(pdone), .page_buf_idx_i(buf_idx), .page_buf_data_o(buf_word));
	ffpi_prog_model u_ffpi_prog_model (
		.mclk_i(mclk_i), .ready_i(ready), .valid_n_i(valid_n), .dat_i(bus),
		.strobe_n_o(strobe_n), .oe_n_o(oe_n), .mode_o(mode), .dat_o(drv_data),
		.en_o(drv_en), .hang_o(hang));

	// Flash model: every word reads as the two halves of its address folded together.
	always begin
		@(posedge mclk_i iff rd_req);
		repeat (2) @(posedge mclk_i);
		#1 rd_data = rd_addr[15:0] ^ rd_addr[31:16];
		rd_done = 1'b1;
		@(posedge mclk_i);
		#1 rd_done = 1'b0;
	end
	// Commit model: logs the page, its flags and all four buffer words, then acknowledges.
	always begin
		logic [63:0] w;
		@(posedge mclk_i iff prog_req);
		for (int i = 0; i < 4; i++) begin
			#1 buf_idx = 2'(i);
			#1 w = {w[47:0], buf_word};
		end
		c_addr.push_back(prog_addr);
		c_fl.push_back({erase, lock});
		c_w.push_back(w);
		@(posedge mclk_i);
		#1 pdone = 1'b1;
		@(posedge mclk_i);
		#1 pdone = 1'b0;
	end
	// A hung handshake ends the run as a failure.
	always @(posedge hang) begin
		fail_count++;
		tally_and_finish();
	end

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic chk_commit(input logic [31:0] a, input logic [1:0] fl, input logic [63:0] w);
		if (c_addr.size() == 0) chk("commit count", 64'h1, 64'h0);
		else begin
			chk("commit page", a, c_addr.pop_front());
			chk("commit flags", fl, c_fl.pop_front());
			chk("commit words", w, c_w.pop_front());
		end
	endtask : chk_commit

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish

	// Reset levels, then the external clock must be taken by the time ready first rises.
	task automatic t_startup();
		@(posedge mclk_i);
		#1 chk("reset pins", 3'b010, {ready, valid_n, data_oe});
		@(posedge mclk_i);
		#1 srst_i = 1'b0;
		u_ffpi_prog_model.wt(1'b0, 1'b1);
		chk("ext clock taken", 1'b1, ext_sel);
	endtask : t_startup

	// Page write crossing a page, with an upper address part, flushed by the next command.
	task automatic t_page_write();
		u_ffpi_prog_model.wr(MODE_COMMAND, CMD_PAGE_WRITE);
		u_ffpi_prog_model.wr(MODE_ADDR_PART0, 16'h0006);
		u_ffpi_prog_model.wr(4'h2, 16'h0001);
		u_ffpi_prog_model.wr(MODE_DATA, 16'ha1a1);
		u_ffpi_prog_model.wr(MODE_DATA, 16'hb2b2);
		u_ffpi_prog_model.wr(MODE_DATA, 16'hc3c3);
		chk_commit(32'h0001_0004, 2'h0, 64'hffff_ffff_a1a1_b2b2);
		u_ffpi_prog_model.wr(MODE_COMMAND, CMD_READ);
		chk_commit(32'h0001_0008, 2'h0, 64'hc3c3_ffff_ffff_ffff);
	endtask : t_page_write

	// Every write variant, committed by a following read command with its erase and lock flags.
	task automatic t_variants();
		logic [15:0] cmds[4];
		logic [15:0] a;
		cmds = '{CMD_PAGE_WRITE, CMD_PAGE_WRITE_LOCK, CMD_ERASE_THEN_WRITE, CMD_ERASE_WRITE_LOCK};
		for (int k = 0; k < 4; k++) begin
			a = 16'h0010 + 16'(k * 4);
			// Pages 4 to 7 in turn: plain write first, then the locking, erasing and erase-lock writes.
			u_ffpi_prog_model.wr(MODE_COMMAND, cmds[k]);
			u_ffpi_prog_model.wr(MODE_ADDR_PART0, a);
			u_ffpi_prog_model.wr(4'h2, 16'h0000);
			u_ffpi_prog_model.wr(MODE_DATA, 16'(k));
			u_ffpi_prog_model.wr(MODE_COMMAND, CMD_READ);
			chk_commit({16'h0000, a}, 2'(k), {16'(k), 48'hffff_ffff_ffff});
		end
	endtask : t_variants

	// Chained reads, an idle mode and an unused address part, then an address reload.
	// A data write under the read command would start a read, so none is sent here.
	task automatic t_read();
		logic [15:0] v;
		u_ffpi_prog_model.wr(MODE_ADDR_PART0, 16'h0040);
		u_ffpi_prog_model.wr(4'h2, 16'h0002);
		for (int k = 0; k < 3; k++) begin
			u_ffpi_prog_model.rd(v);
			chk("read word", (16'h0040 + 16'(k)) ^ 16'h0002, v);
		end
		u_ffpi_prog_model.wr(4'h9, 16'h1234);
		// The third address part lies beyond a 32-bit address on the wide bus, so it is ignored.
		u_ffpi_prog_model.wr(4'h3, 16'h5555);
		u_ffpi_prog_model.rd(v);
		chk("read after idle", 16'h0043 ^ 16'h0002, v);
		chk("no commit", 64'h0, 64'(c_addr.size()));
		u_ffpi_prog_model.wr(MODE_ADDR_PART0, 16'h0080);
		u_ffpi_prog_model.rd(v);
		chk("read reload", 16'h0082, v);
	endtask : t_read

	initial begin
		t_startup();
		t_page_write();
		t_variants();
		t_read();
		tally_and_finish();
	end
endmodule : tb_top

`default_nettype wire

// ===== hdl/ffpi_pkg.sv
// Shared constants and state type for the parallel flash programming port.
package ffpi_pkg;

	// Core clock rate and the slowest external clock that may be switched to.
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned EXT_MIN_HZ = 32_000;
	// One period of the slowest accepted external clock, rounded up to whole cycles.
	localparam int unsigned EXT_PERIOD_CYC = (CLK_HZ + EXT_MIN_HZ - 1) / EXT_MIN_HZ;
	// The detection window spans two such periods; two rising edges prove a clock.
	localparam int unsigned EXT_WIN_PERIODS = 2;
	localparam int unsigned EXT_WIN_CYC = EXT_WIN_PERIODS * EXT_PERIOD_CYC;
	localparam int unsigned EXT_MIN_EDGES = 2;

	// Depth of every pin synchroniser.
	localparam int unsigned SYNC_STAGES = 3;

	// Transfer target selected by the mode lines.
	localparam logic [3:0] MODE_COMMAND = 4'h0;
	localparam logic [3:0] MODE_ADDR_PART0 = 4'h1;
	localparam logic [3:0] MODE_ADDR_PART3 = 4'h4;
	localparam logic [3:0] MODE_DATA = 4'h5;
	localparam int unsigned ADDR_PARTS = 4;

	// Command-phase codes; the 8-bit variant carries only the low byte.
	localparam logic [15:0] CMD_READ = 16'h0011;
	localparam logic [15:0] CMD_PAGE_WRITE = 16'h0012;
	localparam logic [15:0] CMD_PAGE_WRITE_LOCK = 16'h0022;
	localparam logic [15:0] CMD_ERASE_THEN_WRITE = 16'h0032;
	localparam logic [15:0] CMD_ERASE_WRITE_LOCK = 16'h0042;
	localparam logic [15:0] CMD_RESET = 16'h0000;

	// Idle levels of the active-low pins after reset.
	localparam logic STROBE_IDLE = 1'b1;

	// Handshake and execution states.
	typedef enum logic [3:0] {
		S_DETECT,
		S_IDLE,
		S_DECODE,
		S_FLUSH,
		S_READ_WAIT,
		S_OE_WAIT,
		S_DRIVE,
		S_OE_HIGH_WAIT,
		S_DONE_WAIT
	} state_t;

endpackage : ffpi_pkg

// ===== hdl/ffpi_port.sv
// Device-side parallel flash programming port with load buffer and read path.
`timescale 1ns/1ps
`default_nettype none

module ffpi_port
	import ffpi_pkg::*;
#(
	parameter int unsigned DATA_W = 16,
	parameter int unsigned ADDR_W = 32,
	parameter int unsigned PAGE_WORDS = 128,
	parameter int unsigned DETECT_CYC = EXT_WIN_CYC
) (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic srst_i,
	// External clock detection.
	input wire logic ext_clock_in_i,
	output logic ext_clock_select_o,
	// Programmer handshake pins.
	input wire logic command_strobe_n_i,
	input wire logic output_enable_n_i,
	output logic ready_o,
	output logic data_valid_n_o,
	input wire logic [3:0] mode_i,
	// Bidirectional data pins as input, output and enable.
	input wire logic [DATA_W-1:0] data_i,
	output logic [DATA_W-1:0] data_o,
	output logic data_oe_o,
	// Flash read port.
	output logic mem_rd_req_o,
	output logic [ADDR_W-1:0] mem_rd_addr_o,
	input wire logic [DATA_W-1:0] mem_rd_data_i,
	input wire logic mem_rd_done_i,
	// Page commit port.
	output logic page_prog_req_o,
	output logic [ADDR_W-1:0] page_prog_addr_o,
	output logic page_erase_o,
	output logic page_lock_o,
	input wire logic page_prog_done_i,
	input wire logic [$clog2(PAGE_WORDS)-1:0] page_buf_idx_i,
	output logic [DATA_W-1:0] page_buf_data_o
);

	localparam int unsigned PAGE_BITS = $clog2(PAGE_WORDS);
	localparam int unsigned WIN_BITS = $clog2(DETECT_CYC + 1);
	localparam int unsigned EDGE_BITS = $clog2(EXT_MIN_EDGES + 1);
	localparam logic [WIN_BITS-1:0] WIN_LAST = WIN_BITS'(DETECT_CYC - 1);
	localparam logic [EDGE_BITS-1:0] EDGES_NEEDED = EDGE_BITS'(EXT_MIN_EDGES);
	localparam logic [DATA_W-1:0] ERASED_WORD = '1;
	localparam logic [ADDR_W-1:0] ADDR_ONE = ADDR_W'(1);

	state_t state;
	logic [1:0] ctl_sync;
	logic strobe_n;
	logic oe_n;
	logic [3+DATA_W:0] bus_sync;
	logic ext_sync;
	logic ext_prev;
	logic [WIN_BITS-1:0] win_cnt;
	logic [EDGE_BITS-1:0] edge_cnt;
	logic [3:0] cap_mode;
	logic [DATA_W-1:0] cap_data;
	logic [15:0] command;
	logic [ADDR_W-1:0] address;
	logic [DATA_W-1:0] rd_data;
	logic [DATA_W-1:0] page_buf [PAGE_WORDS];
	logic [ADDR_W-PAGE_BITS-1:0] buf_page;
	logic dirty;
	logic is_write_cmd;
	logic cmd_erase;
	logic cmd_lock;
	logic same_page;
	logic do_store;
	logic flush_done;

	// Pins from the programmer are asynchronous, so all pass the filtered synchroniser.
	pin_sync #(.W(2), .RESET_VAL({STROBE_IDLE, STROBE_IDLE})) u_ctl_sync (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.async_i({command_strobe_n_i, output_enable_n_i}),
		.sync_o(ctl_sync)
	);

	// Mode and data take the same delay as the strobe, so they are settled when it is seen.
	pin_sync #(.W(4 + DATA_W), .RESET_VAL('0)) u_bus_sync (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.async_i({mode_i, data_i}),
		.sync_o(bus_sync)
	);

	// The external clock is only counted, never used as a clock here.
	pin_sync #(.W(1), .RESET_VAL(1'b0)) u_ext_sync (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.async_i(ext_clock_in_i),
		.sync_o(ext_sync)
	);

	assign strobe_n = ctl_sync[1];
	assign oe_n = ctl_sync[0];

	// Command decode shared by the store and flush paths.
	always_comb begin
		is_write_cmd = (command == CMD_PAGE_WRITE) || (command == CMD_PAGE_WRITE_LOCK) ||
			(command == CMD_ERASE_THEN_WRITE) || (command == CMD_ERASE_WRITE_LOCK);
		cmd_erase = (command == CMD_ERASE_THEN_WRITE) || (command == CMD_ERASE_WRITE_LOCK);
		cmd_lock = (command == CMD_PAGE_WRITE_LOCK) || (command == CMD_ERASE_WRITE_LOCK);
		same_page = (address[ADDR_W-1:PAGE_BITS] == buf_page);
	end

	// A data write stores only when no commit of another page is pending first.
	assign do_store = (state == S_DECODE) && (cap_mode == MODE_DATA) && is_write_cmd &&
		(!dirty || same_page);
	assign flush_done = (state == S_FLUSH) && page_prog_done_i;

	// Main handshake sequencer.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			state <= S_DETECT;
		end else begin
			case (state)
				S_DETECT: begin
					if (win_cnt == WIN_LAST) begin
						state <= S_IDLE;
					end
				end
				S_IDLE: begin
					if (!strobe_n) begin
						state <= S_DECODE;
					end
				end
				S_DECODE: begin
					case (cap_mode)
						MODE_COMMAND: begin
							state <= dirty ? S_FLUSH : S_DONE_WAIT;
						end
						MODE_DATA: begin
							if (command == CMD_READ) begin
								state <= dirty ? S_FLUSH : S_READ_WAIT;
							end else if (is_write_cmd && dirty && !same_page) begin
								state <= S_FLUSH;
							end else begin
								state <= S_DONE_WAIT;
							end
						end
						default: begin
							state <= S_DONE_WAIT;
						end
					endcase
				end
				S_FLUSH: begin
					if (page_prog_done_i) begin
						state <= S_DECODE;
					end
				end
				S_READ_WAIT: begin
					if (mem_rd_done_i) begin
						state <= S_OE_WAIT;
					end
				end
				S_OE_WAIT: begin
					if (!oe_n) begin
						state <= S_DRIVE;
					end
				end
				S_DRIVE: begin
					state <= S_OE_HIGH_WAIT;
				end
				S_OE_HIGH_WAIT: begin
					if (oe_n) begin
						state <= S_DONE_WAIT;
					end
				end
				S_DONE_WAIT: begin
					if (strobe_n) begin
						state <= S_IDLE;
					end
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

	// Count external clock edges over a fixed window before ready first rises.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			ext_prev <= 1'b0;
			win_cnt <= '0;
			edge_cnt <= '0;
		end else begin
			ext_prev <= ext_sync;
			if (state == S_DETECT) begin
				win_cnt <= win_cnt + WIN_BITS'(1);
				if (ext_sync && !ext_prev && edge_cnt != EDGES_NEEDED) begin
					edge_cnt <= edge_cnt + EDGE_BITS'(1);
				end
			end
		end
	end

	// The choice is made once; a clock that appears later is ignored until the next reset.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			ext_clock_select_o <= 1'b0;
		end else if (state == S_DETECT && win_cnt == WIN_LAST) begin
			ext_clock_select_o <= (edge_cnt == EDGES_NEEDED);
		end
	end

	// Ready is low until detection ends and from capture until the strobe is back high.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			ready_o <= 1'b0;
		end else if (state == S_DETECT && win_cnt == WIN_LAST) begin
			ready_o <= 1'b1;
		end else if (state == S_IDLE && !strobe_n) begin
			ready_o <= 1'b0;
		end else if (state == S_DONE_WAIT && strobe_n) begin
			ready_o <= 1'b1;
		end
	end

	// Mode and data are latched on the cycle the strobe is seen low.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			cap_mode <= '0;
			cap_data <= '0;
		end else if (state == S_IDLE && !strobe_n) begin
			cap_mode <= bus_sync[3+DATA_W:DATA_W];
			cap_data <= bus_sync[DATA_W-1:0];
		end
	end

	// The command is taken only after any pending page has been committed.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			command <= CMD_RESET;
		end else if (state == S_DECODE && cap_mode == MODE_COMMAND && !dirty) begin
			command <= 16'(cap_data);
		end
	end

	// Address parts load in place; each stored data write or completed read then steps to the next word.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			address <= '0;
		end else if (state == S_DECODE) begin
			for (int k = 0; k < ADDR_PARTS; k++) begin
				if (cap_mode == MODE_ADDR_PART0 + 4'(k) && k * DATA_W < ADDR_W) begin
					address <= (address & ~(ADDR_W'(ERASED_WORD) << (k * DATA_W))) |
						(ADDR_W'(cap_data) << (k * DATA_W));
				end
			end
			if (do_store) begin
				address <= address + ADDR_ONE;
			end
		end else if (state == S_READ_WAIT && mem_rd_done_i) begin
			address <= address + ADDR_ONE;
		end
	end

	// The load buffer tracks one page; commit flags follow the command that filled it.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			dirty <= 1'b0;
			buf_page <= '0;
			page_erase_o <= 1'b0;
			page_lock_o <= 1'b0;
		end else if (flush_done) begin
			dirty <= 1'b0;
		end else if (do_store) begin
			dirty <= 1'b1;
			buf_page <= address[ADDR_W-1:PAGE_BITS];
			page_erase_o <= cmd_erase;
			page_lock_o <= cmd_lock;
		end
	end

	// One storage word per page entry; entries return to the erased value after a commit.
	for (genvar i = 0; i < PAGE_WORDS; i++) begin : g_page_buf
		always_ff @(posedge mclk_i) begin
			if (srst_i || flush_done) begin
				page_buf[i] <= ERASED_WORD;
			end else if (do_store && address[PAGE_BITS-1:0] == PAGE_BITS'(i)) begin
				page_buf[i] <= cap_data;
			end
		end
	end

	// The port holds the request line until the flash controller reports the page done.
	assign page_prog_req_o = (state == S_FLUSH);
	assign page_prog_addr_o = {buf_page, PAGE_BITS'(0)};
	assign page_buf_data_o = page_buf[page_buf_idx_i];

	// The read request stands until the flash answers with the word.
	assign mem_rd_req_o = (state == S_READ_WAIT);
	assign mem_rd_addr_o = address;

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			rd_data <= '0;
		end else if (state == S_READ_WAIT && mem_rd_done_i) begin
			rd_data <= mem_rd_data_i;
		end
	end

	// Pins turn to outputs one cycle before valid falls, so data is steady when sampled.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			data_o <= '0;
			data_oe_o <= 1'b0;
		end else if (state == S_OE_WAIT && !oe_n) begin
			data_o <= rd_data;
			data_oe_o <= 1'b1;
		end else if (state == S_OE_HIGH_WAIT && oe_n) begin
			data_oe_o <= 1'b0;
		end
	end

	// Valid rises in the same edge as the release, never before the pins are inputs again.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			data_valid_n_o <= 1'b1;
		end else if (state == S_DRIVE) begin
			data_valid_n_o <= 1'b0;
		end else if (state == S_OE_HIGH_WAIT && oe_n) begin
			data_valid_n_o <= 1'b1;
		end
	end

endmodule : ffpi_port

`default_nettype wire

// ===== hdl/pin_sync.sv
// Three-stage pin synchroniser that accepts a change once its last two stages agree.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter int unsigned W = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic srst_i,
	// Asynchronous pins in, filtered levels out.
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);

	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	// Stage one feeds stage two only, so a metastable sample never reaches logic.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			stage1 <= RESET_VAL;
			stage2 <= RESET_VAL;
			stage3 <= RESET_VAL;
		end else begin
			stage1 <= async_i;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// A bit moves only when two settled stages agree, which rejects single glitches.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			sync_o <= RESET_VAL;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (stage2[i] == stage3[i]) begin
					sync_o[i] <= stage3[i];
				end
			end
		end
	end

endmodule : pin_sync

`default_nettype wire
